// ===== tc_consts.svh
// constants for the tape controller command and status block
// Contract
// [R01] write clears status, starts motion; refused if protected
// [R02] odd parity per byte; cyclic then longitudinal check; the code gives the longitudinal character the XOR of all parity bits
// [R03] write at load point first advances 3.75 inches
// [R04] write end-of-operation after check passes and stop
// [R05] data after end-of-block start sets lost data
// [R06] code 10 records bits 8-15; 45 us timeout
// [R07] code 12 splits word; 95 us timeout
// [R08] code 13 erases, writes 0x13 record, sets mark
// [R09] code 73 arms erase; other command disarms it; the code keeps it armed across a refused write or mark
// [R10] space codes 22, 42, 20, 40 decoded
// [R11] space ends with end-of-operation; load point rules
// [R12] code 60 rewinds; refused at load point
// [R13] code 62 takes selected transport off line
// [R14] interrupt bits always executed; acknowledge rules
// [R15] interrupt mode follows bits; zero keeps mode
// [R16] data_out acknowledged when empty and writing
// [R17] data_in acknowledged when full and reading
// [R18] transfer drops request; ready or stop raises
// [R19] status_in word bit layout
// [R20] busy during motion; commands refused while busy
// [R21] end-of-tape latch set and clear conditions
// [R22] transfers set buffer-not-available; ready clears it
// [R23] low accumulator byte is the command code
// [R24] connect selects unit from bits 14 and 15
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH
`define TC_MCLK_MHZ      250
`define TC_LEAD_MIL      3750
`define TC_TAPE_IPS      25
`define TC_LEAD_US       (`TC_LEAD_MIL * 1000 / `TC_TAPE_IPS)
`define TC_BYTE_TO_US    45
`define TC_WORD_TO_US    95
`define TC_CMD_RD_BYTE   8'h01
`define TC_CMD_RD_WORD   8'h03
`define TC_CMD_WR_BYTE   8'h10
`define TC_CMD_WR_WORD   8'h12
`define TC_CMD_WR_MARK   8'h13
`define TC_CMD_SP_RF     8'h22
`define TC_CMD_SP_RB     8'h42
`define TC_CMD_SP_FF     8'h20
`define TC_CMD_SP_FB     8'h40
`define TC_CMD_REWIND    8'h60
`define TC_CMD_OFFLINE   8'h62
`define TC_CMD_SET_ERASE 8'h73
`define TC_INT_MASK      8'hf3
`define TC_MARK_BYTE     8'h13
`define TC_CRC_TAP       9'h003c
`define TC_ST_LEN        4
`define TC_ST_BNA        5
`define TC_ST_REW        6
`define TC_ST_BUSY       8
`define TC_ST_NRDY       9
`define TC_ST_PAR        10
`define TC_ST_PROT       11
`define TC_ST_LP         12
`define TC_ST_LOST       13
`define TC_ST_EOT        14
`define TC_ST_TM         15
`endif

// ===== tc_pkg.sv
// types for the tape controller command and status block
package tc_pkg;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_LEAD  = 7'h02,
        ST_WRITE = 7'h04,
        ST_EOB   = 7'h08,
        ST_WAIT  = 7'h10,
        ST_SPACE = 7'h20,
        ST_READ  = 7'h40
    } tc_state_e;

    typedef struct packed {
        logic [3:0] online;
        logic [3:0] protect;
        logic [3:0] load_pt;
        logic [3:0] end_tape;
        logic [3:0] rewinding;
        logic       moving;
        logic       gap;
        logic       mark;
        logic       lrc_ok;
        logic       lrc_err;
        logic       taken;
        logic       rd_stb;
        logic [7:0] rd_data;
    } tc_tu_in_s;

    typedef struct packed {
        logic [1:0] sel;
        logic       fwd;
        logic       rev;
        logic       rewind;
        logic       erase;
        logic       offline;
        logic       wr_valid;
        logic [8:0] wr_data;
    } tc_tu_out_s;
endpackage : tc_pkg

// ===== tc_tape_ctl.sv
// command decode, data handshake and status for the tape controller
`timescale 1ns/1ns
`include "tc_consts.svh"
module tc_tape_ctl #(
    parameter int unsigned LEAD_CYC    = `TC_LEAD_US * `TC_MCLK_MHZ,
    parameter int unsigned BYTE_TO_CYC = `TC_BYTE_TO_US * `TC_MCLK_MHZ,
    parameter int unsigned WORD_TO_CYC = `TC_WORD_TO_US * `TC_MCLK_MHZ
) (
    // clock, reset, enable
    input  wire logic               MCLK,
    input  wire logic               RST_N,
    input  wire logic               CE,
    // host i/o channel
    input  wire logic               CMD_OUT_STB,
    input  wire logic               DATA_OUT_STB,
    input  wire logic               DATA_IN_STB,
    input  wire logic               STATUS_IN_STB,
    input  wire logic [0:15]        ACC_IN,
    output logic                    ACK,
    output logic                    SRQ,
    output logic      [0:15]        ACC_OUT,
    // tape transports
    input  wire tc_pkg::tc_tu_in_s  TU_IN,
    output tc_pkg::tc_tu_out_s      TU_OUT
);
    tc_pkg::tc_state_e  st_q;
    tc_pkg::tc_tu_in_s  s1_q, s2_q, s3_q;
    logic [31:0] cnt_q;
    logic [7:0]  job_q, pend_q, out_q;
    logic [7:0]  mem_q [0:1];
    logic [8:0]  crc_q, lrc_q, ld_val;
    logic [0:15] rd_q, stw;
    logic [1:0]  sel_q, fcnt_q, ph_q;
    logic fwd_q, rev_q, rew_q, off_q, erase_q, chk_q, out_v_q, par_out_q;
    logic wp_q, rp_q, pend_v_q, bna_q, eoo_q, lost_q, perr_q, tm_q, eot_q;
    logic erase_pend_q, last_wr_q, last_rd_q, rd_full_q, rd_half_q;
    logic dat_en_q, eoo_en_q, srq_q, ack_q;
    logic [7:0] cmd;
    logic [1:0] ib;
    logic on_sel, pr_sel, lp_sel, rw_sel, et_sel, busy, idle_ok;
    logic is_wr, is_mk, is_sp, is_rd, cmd_ok, cmd_go, cmd_ack;
    logic dout_ack, din_ack, gap_ev, mark_ev, ok_ev, err_ev, tk_ev, rd_ev;
    logic out_free, pop, push, emit, done, space_ok, word_m, end_sp, to_hit;
    logic [7:0] push_b;

    // two-flop synchronisers, third stage for edges
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else if (CE)
        begin
            s1_q <= TU_IN;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign gap_ev  = s2_q.gap & ~s3_q.gap;
    assign mark_ev = s2_q.mark & ~s3_q.mark;
    assign ok_ev   = s2_q.lrc_ok & ~s3_q.lrc_ok;
    assign err_ev  = s2_q.lrc_err & ~s3_q.lrc_err;
    assign tk_ev   = s2_q.taken & ~s3_q.taken;
    assign rd_ev   = s2_q.rd_stb & ~s3_q.rd_stb & (st_q == tc_pkg::ST_READ);
    assign on_sel  = s2_q.online[sel_q];
    assign pr_sel  = s2_q.protect[sel_q];
    assign lp_sel  = s2_q.load_pt[sel_q];
    assign rw_sel  = s2_q.rewinding[sel_q];
    assign et_sel  = s2_q.end_tape[sel_q];

    // command decode
    assign cmd     = ACC_IN[8:15] & `TC_INT_MASK; // [R23]
    assign ib      = ACC_IN[12:13];
    assign busy    = (st_q != tc_pkg::ST_IDLE) | s2_q.moving | rw_sel; // [R20]
    assign idle_ok = !busy & on_sel; // [R13]
    assign is_wr   = (cmd == `TC_CMD_WR_BYTE) | (cmd == `TC_CMD_WR_WORD);
    assign is_mk   = (cmd == `TC_CMD_WR_MARK);
    assign is_rd   = (cmd == `TC_CMD_RD_BYTE) | (cmd == `TC_CMD_RD_WORD);
    assign is_sp   = (cmd == `TC_CMD_SP_RF) | (cmd == `TC_CMD_SP_RB)
                   | (cmd == `TC_CMD_SP_FF) | (cmd == `TC_CMD_SP_FB); // [R10]
    always_comb
    begin
        cmd_ok = 1'b0;
        if (ACC_IN[8])
            cmd_ok = !busy; // [R24]
        else if (is_wr || is_mk)
            cmd_ok = idle_ok && !pr_sel; // [R01]
        else if (is_sp)
            cmd_ok = idle_ok && !(cmd[6] && lp_sel); // [R11]
        else if (cmd == `TC_CMD_REWIND)
            cmd_ok = idle_ok && !lp_sel; // [R12]
        else if (is_rd || cmd == `TC_CMD_OFFLINE || cmd == `TC_CMD_SET_ERASE)
            cmd_ok = idle_ok;
    end
    assign cmd_go   = CE & CMD_OUT_STB & cmd_ok;
    assign cmd_ack  = cmd_go | (CE & CMD_OUT_STB & (cmd == 8'h00) & (ib != 2'h0)); // [R14]
    assign dout_ack = CE & DATA_OUT_STB & !bna_q & last_wr_q
                    & (st_q == tc_pkg::ST_WRITE); // [R16]
    assign din_ack  = CE & DATA_IN_STB & !bna_q & last_rd_q & rd_full_q; // [R17]
    assign word_m   = (job_q == `TC_CMD_WR_WORD) | (job_q == `TC_CMD_RD_WORD);
    assign to_hit   = cnt_q == (word_m ? WORD_TO_CYC : BYTE_TO_CYC) - 1;
    assign done     = (st_q == tc_pkg::ST_WAIT) & chk_q & !s2_q.moving; // [R04]
    assign end_sp   = mark_ev | (job_q[1] & gap_ev) | (rev_q & lp_sel); // [R10] [R11]

    // sequencing of motion
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            st_q    <= tc_pkg::ST_IDLE;
            cnt_q   <= '0;
            fwd_q   <= 1'b0;
            rev_q   <= 1'b0;
            erase_q <= 1'b0;
            chk_q   <= 1'b0;
            job_q   <= 8'h00;
        end
        else if (CE)
        begin
            case (st_q)
                tc_pkg::ST_IDLE:
                    if (cmd_go && (is_wr || is_mk || is_sp || is_rd))
                    begin
                        job_q <= cmd;
                        cnt_q <= '0;
                        chk_q <= 1'b0;
                        fwd_q <= !(is_sp && cmd[6]); // [R01]
                        rev_q <= is_sp && cmd[6];
                        erase_q <= (is_wr && erase_pend_q) || is_mk; // [R08] [R09]
                        if (is_sp)
                            st_q <= tc_pkg::ST_SPACE;
                        else if (is_rd)
                            st_q <= tc_pkg::ST_READ;
                        else if (lp_sel || erase_pend_q || is_mk)
                            st_q <= tc_pkg::ST_LEAD; // [R03]
                        else
                            st_q <= tc_pkg::ST_WRITE;
                    end
                tc_pkg::ST_LEAD:
                    if (cnt_q == LEAD_CYC - 1)
                    begin
                        cnt_q   <= '0;
                        erase_q <= 1'b0;
                        st_q    <= (job_q == `TC_CMD_WR_MARK) ? tc_pkg::ST_EOB : tc_pkg::ST_WRITE; // [R03]
                    end
                    else
                        cnt_q <= cnt_q + 32'h0000_0001;
                tc_pkg::ST_WRITE:
                    if (dout_ack || bna_q)
                        cnt_q <= '0;
                    else if (to_hit)
                        st_q <= tc_pkg::ST_EOB; // [R06] [R07]
                    else
                        cnt_q <= cnt_q + 32'h0000_0001;
                tc_pkg::ST_EOB:
                    if (ph_q == 2'h2 && !out_v_q)
                    begin
                        fwd_q <= 1'b0;
                        st_q  <= tc_pkg::ST_WAIT;
                    end
                tc_pkg::ST_WAIT:
                    if (ok_ev || err_ev)
                        chk_q <= 1'b1;
                    else if (done)
                        st_q <= tc_pkg::ST_IDLE;
                tc_pkg::ST_SPACE:
                    if (end_sp)
                    begin
                        fwd_q <= 1'b0;
                        rev_q <= 1'b0;
                        chk_q <= 1'b1;
                        st_q  <= tc_pkg::ST_WAIT;
                    end
                tc_pkg::ST_READ:
                    if (gap_ev)
                    begin
                        fwd_q <= 1'b0;
                        chk_q <= 1'b1;
                        st_q  <= tc_pkg::ST_WAIT;
                    end
                default:
                    st_q <= tc_pkg::ST_IDLE;
            endcase
        end
    end

    // two-entry write buffer
    assign push     = pend_v_q | dout_ack;
    assign push_b   = pend_v_q ? pend_q : (word_m ? ACC_IN[0:7] : ACC_IN[8:15]); // [R06] [R07]
    assign out_free = !out_v_q | tk_ev;
    assign pop      = out_free & (fcnt_q != 2'h0);
    assign emit     = out_free & !pop & !pend_v_q & (st_q == tc_pkg::ST_EOB) & (ph_q != 2'h2);
    assign space_ok = !pend_v_q & (word_m ? (fcnt_q == 2'h0) : (fcnt_q != 2'h2));

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            fcnt_q   <= 2'h0;
            pend_v_q <= 1'b0;
            pend_q   <= 8'h00;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end
        else if (CE)
        begin
            if (push)
            begin
                mem_q[wp_q] <= push_b;
                wp_q        <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            fcnt_q   <= fcnt_q + {1'b0, push} - {1'b0, pop};
            pend_v_q <= dout_ack & word_m;
            if (dout_ack)
                pend_q <= ACC_IN[8:15];
        end
    end

    // transport byte register with parity and check characters
    always_comb
    begin
        ld_val = {~^mem_q[rp_q], mem_q[rp_q]}; // [R02]
        if (!pop)
        begin
            if (ph_q == 2'h1)
                ld_val = lrc_q;
            else if (job_q == `TC_CMD_WR_MARK)
                ld_val = {~^`TC_MARK_BYTE, `TC_MARK_BYTE}; // [R08]
            else
                ld_val = {~^crc_q[7:0], crc_q[7:0]};
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            out_v_q   <= 1'b0;
            out_q     <= 8'h00;
            par_out_q <= 1'b0;
            crc_q     <= 9'h000;
            lrc_q     <= 9'h000;
            ph_q      <= 2'h0;
        end
        else if (CE)
        begin
            if (cmd_go)
            begin
                crc_q <= 9'h000;
                lrc_q <= 9'h000;
                ph_q  <= 2'h0;
            end
            if (pop || emit)
            begin
                out_v_q   <= 1'b1;
                {par_out_q, out_q} <= ld_val;
                lrc_q <= lrc_q ^ ld_val; // [R02]
                if (pop)
                    crc_q <= {crc_q[7:0], 1'b0} ^ {1'b0, ld_val[7:0]}
                           ^ (crc_q[8] ? `TC_CRC_TAP : 9'h000);
                if (emit)
                    ph_q <= ph_q + 2'h1;
            end
            else if (tk_ev)
                out_v_q <= 1'b0;
        end
    end

    // read holding word
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            rd_q      <= 16'h0000;
            rd_full_q <= 1'b0;
            rd_half_q <= 1'b0;
        end
        else if (CE)
        begin
            if (din_ack || cmd_go)
                rd_full_q <= 1'b0;
            if (cmd_go)
                rd_half_q <= 1'b0;
            if (rd_ev && !rd_full_q)
            begin
                if (word_m && !rd_half_q)
                begin
                    rd_q[0:7] <= s2_q.rd_data;
                    rd_half_q <= 1'b1;
                end
                else
                begin
                    rd_q[8:15] <= s2_q.rd_data; // [R17]
                    if (!word_m)
                        rd_q[0:7] <= 8'h00;
                    rd_half_q <= 1'b0;
                    rd_full_q <= 1'b1;
                end
            end
        end
    end

    // status flags
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            bna_q <= 1'b1;
            eoo_q <= 1'b1;
            lost_q <= 1'b0;
            perr_q <= 1'b0;
            tm_q <= 1'b0;
            eot_q <= 1'b0;
            erase_pend_q <= 1'b0;
            last_wr_q <= 1'b0;
            last_rd_q <= 1'b0;
            sel_q <= 2'h0;
        end
        else if (CE)
        begin
            if (cmd_go || dout_ack || din_ack)
                bna_q <= 1'b1; // [R22]
            else if ((st_q == tc_pkg::ST_WRITE) && space_ok)
                bna_q <= 1'b0; // [R22]
            else if (last_rd_q && rd_full_q)
                bna_q <= 1'b0;
            else if (st_q != tc_pkg::ST_WRITE)
                bna_q <= 1'b1; // [R06] [R07]
            if (done || (cmd_go && cmd == `TC_CMD_REWIND))
                eoo_q <= 1'b1; // [R04] [R11] [R12]
            else if (cmd_go && (is_wr || is_mk || is_sp || is_rd))
                eoo_q <= 1'b0; // [R01]
            if (CE && DATA_OUT_STB && last_wr_q && (eoo_q || st_q == tc_pkg::ST_EOB || st_q == tc_pkg::ST_WAIT))
                lost_q <= 1'b1; // [R05]
            else if (cmd_go && (is_wr || is_mk || is_rd))
                lost_q <= 1'b0; // [R01]
            if (err_ev)
                perr_q <= 1'b1;
            else if (cmd_go && (is_wr || is_mk || is_sp || is_rd))
                perr_q <= 1'b0; // [R01]
            if ((st_q == tc_pkg::ST_SPACE && mark_ev) || (done && job_q == `TC_CMD_WR_MARK))
                tm_q <= 1'b1; // [R08] [R11]
            else if (cmd_go && (is_wr || is_mk || is_sp || is_rd))
                tm_q <= 1'b0; // [R01]
            if (fwd_q && et_sel)
                eot_q <= 1'b1; // [R21]
            else if ((rev_q && et_sel) || !on_sel || (cmd_go && ACC_IN[8] && ACC_IN[14:15] != sel_q))
                eot_q <= 1'b0; // [R21]
            if (cmd_go && cmd == `TC_CMD_SET_ERASE)
                erase_pend_q <= 1'b1; // [R09]
            else if (CE && CMD_OUT_STB && (!(is_wr || is_mk) || cmd_go))
                erase_pend_q <= 1'b0; // [R09]
            if (cmd_go && cmd != 8'h00)
            begin
                last_wr_q <= is_wr;
                last_rd_q <= is_rd;
            end
            if (cmd_go && ACC_IN[8])
                sel_q <= ACC_IN[14:15]; // [R24]
        end
    end

    // status word
    always_comb
    begin
        stw                = 16'h0000;
        stw[`TC_ST_REW]    = rw_sel; // [R19]
        stw[`TC_ST_BNA]    = bna_q;
        stw[`TC_ST_LEN]    = 1'b0;
        stw[`TC_ST_BUSY]   = busy;
        stw[`TC_ST_NRDY]   = !on_sel;
        stw[`TC_ST_PAR]    = perr_q;
        stw[`TC_ST_PROT]   = pr_sel;
        stw[`TC_ST_LP]     = lp_sel;
        stw[`TC_ST_LOST]   = lost_q;
        stw[`TC_ST_EOT]    = eot_q;
        stw[`TC_ST_TM]     = tm_q;
    end

    // host answers, interrupt mode and service request
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            ack_q    <= 1'b0;
            ACC_OUT  <= 16'h0000;
            dat_en_q <= 1'b0;
            eoo_en_q <= 1'b0;
            srq_q    <= 1'b0;
            rew_q    <= 1'b0;
            off_q    <= 1'b0;
        end
        else if (CE)
        begin
            ack_q <= cmd_ack | dout_ack | din_ack; // [R14]
            rew_q <= cmd_go && cmd == `TC_CMD_REWIND; // [R12]
            off_q <= cmd_go && cmd == `TC_CMD_OFFLINE; // [R13]
            if (STATUS_IN_STB)
                ACC_OUT <= stw; // [R19]
            else if (din_ack)
                ACC_OUT <= rd_q;
            if (CMD_OUT_STB && ib != 2'h0)
            begin
                dat_en_q <= ib == 2'h2; // [R15]
                eoo_en_q <= ib != 2'h1;
            end
            if ((dat_en_q && bna_q && !bna_d_free()) ||
                (eoo_en_q && !eoo_q && (done || (cmd_go && cmd == `TC_CMD_REWIND))))
                srq_q <= 1'b1; // [R18]
            else if (dout_ack || din_ack || STATUS_IN_STB || (CMD_OUT_STB && ib[0]))
                srq_q <= 1'b0; // [R18]
        end
    end

    function automatic logic bna_d_free();
        bna_d_free = !(((st_q == tc_pkg::ST_WRITE) && space_ok && !dout_ack)
                     || (last_rd_q && rd_full_q && !din_ack));
    endfunction : bna_d_free

    assign ACK    = ack_q;
    assign SRQ    = srq_q;
    assign TU_OUT = {sel_q, fwd_q, rev_q, rew_q, erase_q, off_q, out_v_q, par_out_q, out_q};

    // checks
    a_write_protect: assert property (@(posedge MCLK) disable iff (!RST_N)
        CE && CMD_OUT_STB && (is_wr || is_mk) && pr_sel |=> !ACK)
        else $error("write taken on protected unit"); // [R01]
    a_byte_parity: assert property (@(posedge MCLK) disable iff (!RST_N)
        out_v_q && ph_q != 2'h2 && st_q != tc_pkg::ST_EOB |-> par_out_q == ~^out_q)
        else $error("recorded byte parity not odd"); // [R02]
    a_lead_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
        st_q == tc_pkg::ST_LEAD && cnt_q < LEAD_CYC - 1 |=> st_q == tc_pkg::ST_LEAD)
        else $error("lead-in left early"); // [R03]
    a_lost_data: assert property (@(posedge MCLK) disable iff (!RST_N)
        CE && DATA_OUT_STB && last_wr_q && (eoo_q || st_q == tc_pkg::ST_WAIT) |=> lost_q)
        else $error("late data did not set lost data"); // [R05]
    a_rewind_lp: assert property (@(posedge MCLK) disable iff (!RST_N)
        CE && CMD_OUT_STB && cmd == `TC_CMD_REWIND && lp_sel |=> !ACK)
        else $error("rewind at load point acknowledged"); // [R12]
    a_busy_refuse: assert property (@(posedge MCLK) disable iff (!RST_N)
        CE && CMD_OUT_STB && busy && cmd != 8'h00 |=> !ACK)
        else $error("command acknowledged while busy"); // [R20]
    a_dout_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
        CE && DATA_OUT_STB && (bna_q || !last_wr_q) && !CMD_OUT_STB |=> !ACK)
        else $error("data_out acknowledged while unavailable"); // [R16]
    a_din_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
        CE && DATA_IN_STB && !rd_full_q && !CMD_OUT_STB |=> !ACK)
        else $error("data_in acknowledged with empty buffer"); // [R17]
    a_xfer_bna: assert property (@(posedge MCLK) disable iff (!RST_N)
        dout_ack || din_ack |=> bna_q)
        else $error("transfer left buffer available"); // [R22]
    a_status_busy: assert property (@(posedge MCLK) disable iff (!RST_N)
        CE && STATUS_IN_STB |=> ACC_OUT[`TC_ST_BUSY] == $past(busy)
        && ACC_OUT[`TC_ST_BNA] == $past(bna_q)) else $error("status word misplaced"); // [R19]
    c_write_done: cover property (@(posedge MCLK) disable iff (!RST_N) done && last_wr_q);
    c_space_mark: cover property (@(posedge MCLK) disable iff (!RST_N) st_q == tc_pkg::ST_SPACE && mark_ev);
    c_write_timeout: cover property (@(posedge MCLK) disable iff (!RST_N) st_q == tc_pkg::ST_WRITE && to_hit);
endmodule : tc_tape_ctl

// ===== tc_tape_model.sv
// tape transport stand-in for the controller's transport port
`timescale 1ns/1ns
module tc_tape_model (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // transport port
    input  wire tc_pkg::tc_tu_out_s tu_out,
    output tc_pkg::tc_tu_in_s       tu_in,
    // first recorded character
    output logic [8:0]              first_wr
);
    logic [3:0] cnt_q;
    logic [3:0] lrc_q;
    logic [3:0] online_q;
    logic [3:0] lp_q;
    logic       got_q;
    logic       fwd_q;
    always_comb
    begin
        tu_in         = '0;
        tu_in.online  = online_q;
        tu_in.protect = 4'b0010;
        tu_in.load_pt = lp_q;
        tu_in.moving  = fwd_q | tu_out.rev;
        tu_in.taken   = cnt_q >= 4'h3 && cnt_q <= 4'h6;
        tu_in.lrc_ok  = lrc_q != 4'h0;
    end
    // slow take handshake, lrc check after motion ends
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q    <= 4'h0;
            lrc_q    <= 4'h0;
            online_q <= 4'hf;
            lp_q     <= 4'hf;
            got_q    <= 1'b0;
            fwd_q    <= 1'b0;
            first_wr <= 9'h000;
        end
        else
        begin
            fwd_q <= tu_out.fwd;
            cnt_q <= (cnt_q != 4'h0 || tu_out.wr_valid) ? cnt_q + 4'h1 : 4'h0;
            lrc_q <= (fwd_q && !tu_out.fwd) ? 4'h4 : lrc_q - {3'h0, lrc_q != 4'h0};
            if (cnt_q == 4'h2 && !got_q)
            begin
                first_wr <= tu_out.wr_data;
                got_q    <= 1'b1;
            end
            if (tu_out.fwd)
                lp_q[tu_out.sel] <= 1'b0;
            if (tu_out.rewind)
                lp_q[tu_out.sel] <= 1'b1;
            if (tu_out.offline)
                online_q[tu_out.sel] <= 1'b0;
        end
    end
endmodule : tc_tape_model

// ===== tb.sv
// self-checking bench for the tape controller command block
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb;
    logic               mclk = 1'b0;
    logic               rst_n = 1'b0;
    logic [3:0]         stb = 4'h0;
    logic [0:15]        acc_in = 16'h0000;
    logic               ack;
    logic               srq;
    logic [0:15]        acc_out;
    logic [8:0]         first_wr;
    tc_pkg::tc_tu_in_s  tu_in;
    tc_pkg::tc_tu_out_s tu_out;
    int                 error_cnt = 0;
    int                 n_tests = 0;
    always #2 mclk = ~mclk;
    tc_tape_ctl #(.LEAD_CYC(20), .BYTE_TO_CYC(16), .WORD_TO_CYC(24)) dut_u (
        .MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .CMD_OUT_STB(stb[0]), .DATA_OUT_STB(stb[1]),
        .DATA_IN_STB(stb[2]), .STATUS_IN_STB(stb[3]), .ACC_IN(acc_in), .ACK(ack), .SRQ(srq),
        .ACC_OUT(acc_out), .TU_IN(tu_in), .TU_OUT(tu_out));
    tc_tape_model tm_u (.clk(mclk), .rst_n(rst_n), .tu_out(tu_out), .tu_in(tu_in), .first_wr(first_wr));
    // one strobe of kind k, acknowledge expected as e
    task automatic op(input int k, input logic [0:15] v, input logic e);
        @(posedge mclk);
        stb[k] <= 1'b1;
        acc_in <= v;
        @(posedge mclk);
        stb <= 4'h0;
        #1;
        if (k != 3) `CHK(ack, e)
    endtask : op
    task automatic st(input logic [0:15] x);
        op(3, 16'h0000, 1'b0);
        `CHK(acc_out, x)
    endtask : st
    task automatic idle;
        for (int i = 0; i < 300; i++)
        begin
            op(3, 16'h0000, 1'b0);
            if (acc_out[8] === 1'b0)
                break;
        end
    endtask : idle
    task automatic wrap_up;
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        st(16'h0408);
        op(0, 16'h0042, 1'b0);
        op(0, 16'h0060, 1'b0);
        op(0, 16'h008d, 1'b1);
        op(0, 16'h0010, 1'b0);
        st(16'h0418);
        op(0, 16'h008c, 1'b1);
        op(0, 16'h0008, 1'b1);
        op(0, 16'h0018, 1'b1);
        for (int i = 0; i < 100 && srq !== 1'b1; i++)
            @(posedge mclk);
        `CHK(srq, 1'b1)
        op(1, 16'h12a5, 1'b1);
        op(1, 16'h005a, 1'b1);
        op(0, 16'h0022, 1'b0);
        op(2, 16'h0000, 1'b0);
        idle();
        `CHK(first_wr, 9'h1a5)
        st(16'h0400);
        op(1, 16'h0001, 1'b0);
        st(16'h0404);
        op(0, 16'h0013, 1'b1);
        idle();
        st(16'h0401);
        op(0, 16'h0060, 1'b1);
        repeat (4) @(posedge mclk);
        op(3, 16'h0000, 1'b0);
        `CHK(acc_out[12], 1'b1)
        op(0, 16'h0062, 1'b1);
        repeat (4) @(posedge mclk);
        op(0, 16'h0010, 1'b0);
        op(3, 16'h0000, 1'b0);
        `CHK(acc_out[9], 1'b1)
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
endmodule : tb
